/* btx_block_transform.sv */
`timescale 1ns/10ps
`include "btx_defs.svh"
// Contract
// [R1] one sample in, one result out, every clock
// [R2] start strobe marks first sample, captures select
// [R3] next 63 cycles ignore strobe and select
// [R4] 64 samples per block, columns of eight
// [R5] column stage, transpose memory, row stage
// [R6] intermediate results rounded to 16 bits
// [R7] each array multiplies in 64 cycles, unrounded
// [R8] results leave in rows, 64 per block
// [R9] first result exactly 128 cycles after start
// [R10] forward mode may subtract auxiliary input first
// [R11] inverse mode may add auxiliary input after
// [R12] four coefficient sets, transpose is unity
// [R13] 14-bit coefficients in four read-only banks
// [R14] select 000 or 100 means forward transform
// [R15] caller holds strobe low 63 cycles initially
// [R16] 12-bit ports, 9-bit auxiliary, two's complement
// [R17] 9-bit values use upper bits, low zero
// [R18] blocks may follow back to back
module btx_block_transform
	import btx_pkg::*;
(
	input  wire logic              clk,                  // 100 MHz system clock
	input  wire logic              nrst,                 // synchronous reset, active low
	input  wire logic              blockStart,           // high with first sample of a block
	input  wire logic [2:0]        funcSel,              // function select, taken at start
	input  wire logic signed [11:0] pixelIn,             // input sample
	input  wire logic signed [8:0] auxiliaryOperandPort, // subtract / add operand
	output logic signed [11:0]     resultOut,            // result sample
	output logic                   resultValid,          // result stream active
	output logic                   resultFirst           // first result of a block
);

	localparam int TW1 = 10;
	localparam int TW2 = 8;

	btx_stage_if #(.IW(12), .OW(29), .TW(TW1)) s1 ();
	btx_stage_if #(.IW(16), .OW(33), .TW(TW2)) s2 ();

	btxInState_t          inState_q;
	logic [5:0]           inIdx_q;
	btxMode_t             modeIn_q;
	logic [1:0]           wrBank_q;
	logic                 take;
	logic [5:0]           curIdx;
	btxMode_t             curMode;
	logic [1:0]           curBank;
	logic signed [11:0]   pre;
	btxMode_t             t1Mode;
	logic [1:0]           t1Bank;
	logic [2:0]           t1Col;
	logic signed [15:0]   wrData;
	logic                 lastWr;
	logic signed [15:0]   tram [192];
	logic                 waitOn_q;
	logic [5:0]           waitCnt_q;
	logic [1:0]           pendBank_q;
	btxMode_t             pendMode_q;
	logic                 rdOn_q;
	logic [5:0]           rdIdx_q;
	logic [1:0]           rdBank_q;
	btxMode_t             rdMode_q;
	btxMode_t             oMode;
	logic [2:0]           oRow;
	logic signed [8:0]    aux_q [3];
	logic signed [33:0]   v2;
	logic signed [8:0]    r9;
	logic signed [11:0]   res_d;
	logic signed [11:0]   resultOut_q;
	logic                 resultValid_q;
	logic                 resultFirst_q;

	// the three transpose banks are used in turn
	function automatic logic [1:0] btx_next_bank(input logic [1:0] b);
		return (b == 2'h2) ? 2'h0 : b + 2'h1;
	endfunction

	// [R2] [R14] start-cycle capture
	always_comb
	begin
		take = (inState_q == IN_TAKE) || blockStart;
		if (inState_q == IN_IDLE)
		begin
			curIdx = 6'h00;
			curMode = btx_decode(funcSel);
			curBank = btx_next_bank(wrBank_q);
		end
		else
		begin
			curIdx = inIdx_q;
			curMode = modeIn_q;
			curBank = wrBank_q;
		end
	end

	// [R10] [R16] [R17] forward input is the upper nine bits, optionally minus aux
	always_comb
	begin
		pre = pixelIn;
		if (curMode.func == FN_DCT)
		begin
			if (curMode.subEn)
				// the part-select is unsigned, so it is re-signed before widening
				pre = 12'(9'(btx_sat(34'($signed(pixelIn[11:3])) - 34'(auxiliaryOperandPort),
					`BTX_W_PIX)));
			else
				pre = 12'($signed(pixelIn[11:3]));
		end
	end

	// [R3] [R4] [R15] strobe and select only looked at while idle
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			inState_q <= IN_IDLE;
			inIdx_q <= 6'h00;
			modeIn_q <= '0;
			wrBank_q <= 2'h0;
		end
		else
		begin
			unique case (inState_q)
				IN_IDLE:
				begin
					if (blockStart)
					begin
						inState_q <= IN_TAKE;
						inIdx_q <= 6'h01;
						modeIn_q <= curMode;
						wrBank_q <= curBank;
					end
				end
				IN_TAKE:
				begin
					inIdx_q <= inIdx_q + 6'h01;
					// [R18] idle again right after sample 63
					if (inIdx_q == `BTX_BLK_LAST)
						inState_q <= IN_IDLE;
				end
			endcase
		end
	end

	// [R1] [R4] every taken sample feeds the column stage
	always_ff @(posedge clk)
	begin
		if (!nrst)
			s1.inValid <= 1'b0;
		else
			s1.inValid <= take;
		s1.inData <= pre;
		s1.inM <= curIdx[2:0];
		s1.inFunc <= curMode.func;
		s1.inTag <= {curMode, curBank, curIdx[5:3]};
	end

	// [R5] column stage
	btx_mat_stage #(.OW(29)) uCol (
		.clk  (clk),
		.nrst (nrst),
		.s    (s1)
	);

	assign {t1Mode, t1Bank, t1Col} = s1.outTag;
	assign lastWr = s1.outValid && t1Col == `BTX_GRP_LAST && s1.outK == `BTX_GRP_LAST;

	// [R6] 16-bit selector between the stages
	always_comb
	begin
		wrData = 16'(btx_sat(btx_round(34'(s1.outData),
			(t1Mode.func == FN_DCT) ? `BTX_S1_DCT : `BTX_S1_OTHER), `BTX_W_MID));
	end

	// [R5] column results stored row-major, so reading in order transposes
	always_ff @(posedge clk)
	begin
		if (s1.outValid)
			tram[{t1Bank, s1.outK, t1Col}] <= wrData;
	end

	// [R9] row read deferred so the output lands 128 cycles after start;
	// three banks keep a deferred read clear of the next two blocks' writes
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			waitOn_q <= 1'b0;
			waitCnt_q <= 6'h00;
			pendBank_q <= 2'h0;
			pendMode_q <= '0;
			rdOn_q <= 1'b0;
			rdIdx_q <= 6'h00;
			rdBank_q <= 2'h0;
			rdMode_q <= '0;
		end
		else
		begin
			if (rdOn_q)
			begin
				rdIdx_q <= rdIdx_q + 6'h01;
				if (rdIdx_q == `BTX_BLK_LAST)
					rdOn_q <= 1'b0;
			end
			if (lastWr)
			begin
				waitOn_q <= 1'b1;
				waitCnt_q <= `BTX_RD_WAIT;
				pendBank_q <= t1Bank;
				pendMode_q <= t1Mode;
			end
			else if (waitOn_q)
			begin
				waitCnt_q <= waitCnt_q - 6'h01;
				if (waitCnt_q == 6'h01)
				begin
					waitOn_q <= 1'b0;
					rdOn_q <= 1'b1;
					rdIdx_q <= 6'h00;
					rdBank_q <= pendBank_q;
					rdMode_q <= pendMode_q;
				end
			end
		end
	end

	// [R5] registered memory read feeds the row stage
	always_ff @(posedge clk)
	begin
		if (!nrst)
			s2.inValid <= 1'b0;
		else
			s2.inValid <= rdOn_q;
		s2.inData <= tram[{rdBank_q, rdIdx_q}];
		s2.inM <= rdIdx_q[2:0];
		s2.inFunc <= rdMode_q.func;
		s2.inTag <= {rdMode_q, rdIdx_q[5:3]};
	end

	// [R5] row stage
	btx_mat_stage #(.OW(33)) uRow (
		.clk  (clk),
		.nrst (nrst),
		.s    (s2)
	);

	assign {oMode, oRow} = s2.outTag;

	// [R11] aux arrives four cycles ahead of its result; three stages align it
	always_ff @(posedge clk)
	begin
		aux_q[0] <= auxiliaryOperandPort;
		aux_q[1] <= aux_q[0];
		aux_q[2] <= aux_q[1];
	end

	// [R11] [R17] output selector, adder and clipping
	always_comb
	begin
		unique case (oMode.func)
			FN_DCT: v2 = btx_round(34'(s2.outData), `BTX_S2_DCT);
			FN_IDCT: v2 = btx_round(34'(s2.outData), `BTX_S2_IDCT);
			default: v2 = btx_round(34'(s2.outData), `BTX_S2_OTHER);
		endcase
		r9 = 9'(btx_sat(v2, `BTX_W_PIX));
		if (oMode.addEn)
			r9 = 9'(btx_sat(34'(r9) + 34'(aux_q[2]), `BTX_W_PIX));
		if (oMode.clipEn && r9 < 9'sh000)
			r9 = 9'sh000;
		if (oMode.func == FN_IDCT)
			res_d = {r9, 3'h0};
		else
			res_d = 12'(btx_sat(v2, `BTX_W_OUT));
	end

	// [R1] [R8] registered result stream
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			resultOut_q <= 12'sh000;
			resultValid_q <= 1'b0;
			resultFirst_q <= 1'b0;
		end
		else
		begin
			// zero between blocks: the row stage holds unknown sums until first used
			resultOut_q <= s2.outValid ? res_d : 12'sh000;
			resultValid_q <= s2.outValid;
			resultFirst_q <= s2.outValid && oRow == 3'h0 && s2.outK == 3'h0;
		end
	end

	assign resultOut = resultOut_q;
	assign resultValid = resultValid_q;
	assign resultFirst = resultFirst_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_first_latency: // [R9]
	assert property (inState_q == IN_IDLE && blockStart |-> ##128 resultFirst_q)
	else $error("first result not 128 cycles after block start");

	a_take_hold: // [R3]
	assert property (inState_q == IN_TAKE && inIdx_q != 6'h3f
		|=> inState_q == IN_TAKE && $stable(modeIn_q) && $stable(wrBank_q))
	else $error("block capture disturbed by strobe or select");

	a_block_len: // [R4]
	assert property (inState_q == IN_IDLE && blockStart |=> inIdx_q == 6'h01
		##62 (inState_q == IN_TAKE && inIdx_q == 6'h3f) ##1 inState_q == IN_IDLE)
	else $error("block did not take exactly 64 samples");

	a_sel_capture: // [R2]
	assert property (inState_q == IN_IDLE && blockStart |=> modeIn_q == btx_decode($past(funcSel)))
	else $error("function select not captured with the start strobe");

	a_fwd_select: // [R14]
	assert property (inState_q == IN_IDLE && blockStart && funcSel[1:0] == 2'h0
		|=> modeIn_q.func == FN_DCT)
	else $error("select 000 or 100 did not choose forward transform");

	a_sub_range: // [R10]
	assert property (take && curMode.subEn |=> s1.inData >= 12'shf00 && s1.inData <= 12'sh0ff)
	else $error("subtractor result not saturated to nine bits");

	a_read_start: // [R5]
	assert property (lastWr |-> ##46 (rdOn_q && rdIdx_q == 6'h00 && !waitOn_q
		&& rdBank_q == $past(t1Bank, 46)))
	else $error("row read did not start on schedule");

	a_low_zero: // [R17]
	assert property (s2.outValid && oMode.func == FN_IDCT |=> resultOut_q[2:0] == 3'h0)
	else $error("nine-bit result has nonzero low bits");

	a_clip_pos: // [R11]
	assert property (s2.outValid && oMode.clipEn |=> !resultOut_q[11])
	else $error("clipped result is negative");

	a_row_out: // [R8]
	assert property (resultFirst_q |-> resultValid_q ##1 (resultValid_q && !resultFirst_q)[*7])
	else $error("first output row not eight results long");

	c_back_to_back: cover property (inState_q == IN_TAKE && inIdx_q == 6'h3f ##1 blockStart);
	c_sub_block: cover property (inState_q == IN_IDLE && blockStart && funcSel == 3'h4);
	c_add_out: cover property (resultValid_q && $past(oMode.addEn));
	c_first_out: cover property (resultFirst_q);

endmodule

/* btx_block_transform_bench.sv */
`timescale 1ns/10ps
module btx_block_transform_bench
	import btx_pkg::*;
;
	logic               clk = 1'b0;
	logic               nrst = 1'b0;
	logic               blockStart;
	logic [2:0]         funcSel;
	logic signed [11:0] pixelIn;
	logic signed [8:0]  auxOp;
	logic signed [11:0] resultOut;
	logic               resultValid;
	logic               resultFirst;
	logic signed [11:0] expVal[0:127];
	int                 errors = 0;
	int                 nCompared = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	btx_block_transform btx_block_transform_i (
		.clk                  (clk),
		.nrst                 (nrst),
		.blockStart           (blockStart),
		.funcSel              (funcSel),
		.pixelIn              (pixelIn),
		.auxiliaryOperandPort (auxOp),
		.resultOut            (resultOut),
		.resultValid          (resultValid),
		.resultFirst          (resultFirst)
	);

	btx_stream_partner btx_stream_partner_i (
		.clk         (clk),
		.resultOut   (resultOut),
		.resultValid (resultValid),
		.resultFirst (resultFirst),
		.blockStart  (blockStart),
		.funcSel     (funcSel),
		.pixelIn     (pixelIn),
		.auxOp       (auxOp)
	);

	// shared comparison, four-state so an unknown never matches a known value
	task automatic compare(input logic [11:0] got, input logic [11:0] want, input string what);
		nCompared++;
		if (got !== want)
		begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, want);
		end
	endtask

	// stream nb blocks through the partner and judge count, latency and data
	task automatic run_blocks(input logic [2:0] s0, input logic [2:0] s1, input int nb,
		input int lag, input string name);
		int t;
		btx_stream_partner_i.sel[0] = s0;
		btx_stream_partner_i.sel[1] = s1;
		btx_stream_partner_i.nBlk = nb;
		btx_stream_partner_i.auxLag = lag;
		btx_stream_partner_i.nGot = 0;
		btx_stream_partner_i.nFirst = 0;
		@(posedge clk);
		btx_stream_partner_i.k = 0;
		t = 0;
		while (btx_stream_partner_i.k != -1 && t < 1000)
		begin
			@(posedge clk);
			t++;
		end
		if (t >= 1000)
		begin
			errors++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
		end
		// one result per cycle, 64 per block
		compare(12'(btx_stream_partner_i.nGot), 12'(64 * nb), "result count");
		compare(12'(btx_stream_partner_i.nFirst), 12'(nb), "block count");
		for (int b = 0; b < nb; b++)
			compare(12'(btx_stream_partner_i.firstAt[b]), 12'(128 + 64 * b), "latency");
		for (int i = 0; i < 64 * nb; i++)
			compare(btx_stream_partner_i.got[i], expVal[i], "result sample");
		$display("test %s done", name);
	endtask

	task automatic test_reset();
		compare(resultOut, 12'h000, "reset result");
		compare(12'(resultValid), 12'h000, "reset valid");
		compare(12'(resultFirst), 12'h000, "reset first");
		$display("test reset done");
	endtask

	task automatic test_transpose();
		// unity banks, back to back, output is the transposed input
		for (int i = 0; i < 128; i++)
			btx_stream_partner_i.pix[i] = 12'(i * 16 - 1000);
		for (int i = 0; i < 128; i++)
			expVal[i] = btx_stream_partner_i.pix[(i & 64) | ((i & 7) << 3) | ((i >> 3) & 7)];
		run_blocks(3'h6, 3'h7, 2, 0, "transpose");
	endtask

	task automatic test_filter();
		// filter bank passes a flat block unchanged
		for (int i = 0; i < 64; i++)
		begin
			btx_stream_partner_i.pix[i] = -12'sh2bc;
			expVal[i] = -12'sh2bc;
		end
		run_blocks(3'h2, 3'h2, 1, 0, "filter");
	endtask

	task automatic test_dct();
		// flat block gives 8x DC, low input bits ignored
		for (int i = 0; i < 128; i++)
		begin
			btx_stream_partner_i.pix[i] = (i < 64) ? 12'((-200 <<< 3) | 5) : 12'((-256 <<< 3) | 3);
			btx_stream_partner_i.aux[i] = (i < 64) ? 9'sh064 : 9'sh0ff;
			expVal[i] = 12'sh000;
		end
		// second block subtracts 255 from -256, saturating to -256
		expVal[0] = -12'sh640;
		expVal[64] = -12'sh800;
		run_blocks(3'h0, 3'h4, 2, 0, "forward");
	endtask

	task automatic test_idct_clip();
		// DC only: -60 rounds to -7, clipped to 0 in the second block
		for (int i = 0; i < 128; i++)
		begin
			btx_stream_partner_i.pix[i] = (i % 64 == 0) ? -12'sh03c : 12'sh000;
			btx_stream_partner_i.aux[i] = 9'sh032;
			expVal[i] = (i < 64) ? -12'sh038 : 12'sh000;
		end
		run_blocks(3'h1, 3'h3, 2, 0, "inverse clip");
	endtask

	task automatic test_idct_add();
		// 8 plus operand, saturated to 255 or clipped to 0
		for (int i = 0; i < 64; i++)
		begin
			btx_stream_partner_i.pix[i] = (i == 0) ? 12'sh040 : 12'sh000;
			btx_stream_partner_i.aux[i] = (i % 2 == 0) ? 9'sh0fa : -9'sh014;
			expVal[i] = (i % 2 == 0) ? 12'sh7f8 : 12'sh000;
		end
		run_blocks(3'h5, 3'h5, 1, 124, "inverse add");
	endtask

	// single exit of the run
	task automatic printVerdict();
		$display("compared %0d, mismatches %0d", nCompared, errors);
		if (errors == 0 && nCompared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// reset three cycles, then the tests
	initial
	begin
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		test_reset();
		test_transpose();
		test_filter();
		test_dct();
		test_idct_clip();
		test_idct_add();
		printVerdict();
	end

	// watchdog: the runs need under 2000 cycles
	initial
	begin
		#100000;
		errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		printVerdict();
	end
endmodule

/* btx_defs.svh */
`ifndef BTX_DEFS_SVH
`define BTX_DEFS_SVH

// block and column geometry
`define BTX_BLK_LAST 6'h3f
`define BTX_GRP_LAST 3'h7

// cycles from the last transpose write to the first row read, counted down
`define BTX_RD_WAIT 6'h2d

// bit-field selector shifts (bits rounded away) per function and stage
`define BTX_S1_DCT 8
`define BTX_S1_OTHER 12
`define BTX_S2_DCT 19
`define BTX_S2_IDCT 15
`define BTX_S2_OTHER 12

// result bit-field widths
`define BTX_W_MID 16
`define BTX_W_OUT 12
`define BTX_W_PIX 9

`endif

/* btx_mat_stage.sv */
`timescale 1ns/10ps
`include "btx_defs.svh"
// eight parallel MACs: one group of eight samples in, eight sums out serially
module btx_mat_stage
	import btx_pkg::*;
#(
	parameter int OW = 29
)
(
	input  wire logic  clk,  // system clock
	input  wire logic  nrst, // synchronous reset, active low
	btx_stage_if.stage s     // sample feed and result stream
);

	logic signed [OW-1:0] acc_q [8];
	logic signed [OW-1:0] hold_q [8];
	logic signed [OW-1:0] sum_d [8];
	logic [s.TW-1:0]      tag_q;
	logic                 oRun_q;
	logic [2:0]           oIdx_q;

	// scaled cosine sqrt2*c(k)*cos((2m+1)k*pi/16) in 14-bit fixed point
	function automatic logic signed [13:0] btx_cos(input logic [2:0] k, input logic [2:0] m);
		logic [6:0]          n;
		logic [4:0]          f;
		logic                neg;
		logic signed [13:0]  v;
		n = 7'((7'(m) * 7'h2 + 7'h1) * 7'(k));
		f = n[4:0];
		if (f > 5'h10)
			f = 5'(6'h20 - 6'(f));
		neg = (f > 5'h08);
		if (neg)
			f = 5'h10 - f;
		unique case (f)
			5'h00: v = 14'sh16a1;
			5'h01: v = 14'sh1631;
			5'h02: v = 14'sh14e8;
			5'h03: v = 14'sh12d0;
			5'h04: v = 14'sh1000;
			5'h05: v = 14'sh0c92;
			5'h06: v = 14'sh08a9;
			5'h07: v = 14'sh046a;
			default: v = 14'sh0000;
		endcase
		if (k == 3'h0)
			v = 14'sh1000;
		return neg ? -v : v;
	endfunction

	// [R12] [R13] four read-only banks
	function automatic logic signed [13:0] btx_coef(input btxFunc_t fn, input logic [2:0] k,
		input logic [2:0] m);
		logic signed [13:0] c;
		c = 14'sh0000;
		unique case (fn)
			FN_DCT: c = btx_cos(k, m);
			FN_IDCT: c = btx_cos(m, k);
			FN_FILT:
			begin
				if (k == m)
					c = (k == 3'h0 || k == 3'h7) ? 14'sh0c00 : 14'sh0800;
				else if ({1'b0, k} == {1'b0, m} + 4'h1 || {1'b0, m} == {1'b0, k} + 4'h1)
					c = 14'sh0400;
			end
			FN_TRANS: c = (k == m) ? 14'sh1000 : 14'sh0000;
		endcase
		return c;
	endfunction

	// [R7] full-precision products, no rounding inside the array
	always_comb
	begin
		for (int k = 0; k < 8; k++)
		begin
			sum_d[k] = ((s.inM == 3'h0) ? OW'(0) : acc_q[k])
				+ OW'(s.inData) * OW'(btx_coef(s.inFunc, 3'(k), s.inM));
		end
	end

	// accumulators, free of reset: a group always restarts at m = 0
	always_ff @(posedge clk)
	begin
		if (s.inValid)
			acc_q <= sum_d;
	end

	// finished group is parked for serial readout over the next 8 cycles
	always_ff @(posedge clk)
	begin
		if (s.inValid && s.inM == `BTX_GRP_LAST)
		begin
			hold_q <= sum_d;
			tag_q <= s.inTag;
		end
	end

	// readout sequencer
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			oRun_q <= 1'b0;
			oIdx_q <= 3'h0;
		end
		else if (s.inValid && s.inM == `BTX_GRP_LAST)
		begin
			oRun_q <= 1'b1;
			oIdx_q <= 3'h0;
		end
		else if (oRun_q)
		begin
			oIdx_q <= oIdx_q + 3'h1;
			if (oIdx_q == `BTX_GRP_LAST)
				oRun_q <= 1'b0;
		end
	end

	assign s.outValid = oRun_q;
	assign s.outK = oIdx_q;
	assign s.outData = hold_q[oIdx_q];
	assign s.outTag = tag_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_stage_span: // [R7]
	assert property (s.inValid && s.inM == 3'h7 |=> (s.outValid && s.outK == 3'h0)
		##1 (s.outValid && s.outK != 3'h0)[*7])
	else $error("matrix stage did not stream eight results after a group");

endmodule

/* btx_pkg.sv */
package btx_pkg;

	// the four coefficient banks
	typedef enum logic [1:0] {FN_DCT, FN_IDCT, FN_FILT, FN_TRANS} btxFunc_t;

	// decoded function select
	typedef struct packed {
		btxFunc_t func;
		logic     subEn;
		logic     addEn;
		logic     clipEn;
	} btxMode_t;

	typedef enum logic {IN_IDLE, IN_TAKE} btxInState_t;

	// select lines to function and arithmetic options
	function automatic btxMode_t btx_decode(input logic [2:0] sel);
		btxMode_t m;
		m = '{func: FN_TRANS, subEn: 1'b0, addEn: 1'b0, clipEn: 1'b0};
		unique case (sel)
			3'h0: m.func = FN_DCT;
			3'h4:
			begin
				m.func = FN_DCT;
				m.subEn = 1'b1;
			end
			3'h1: m.func = FN_IDCT;
			3'h3:
			begin
				m.func = FN_IDCT;
				m.clipEn = 1'b1;
			end
			3'h5:
			begin
				m.func = FN_IDCT;
				m.addEn = 1'b1;
				m.clipEn = 1'b1;
			end
			3'h2: m.func = FN_FILT;
			3'h6, 3'h7: m.func = FN_TRANS;
		endcase
		return m;
	endfunction

	// drop sh low bits, rounding toward +inf on the top discarded bit
	function automatic logic signed [33:0] btx_round(input logic signed [33:0] v, input int sh);
		logic signed [33:0] half;
		half = 34'sh1 <<< (sh - 1);
		return (v + half) >>> sh;
	endfunction

	// saturate to an n-bit two's complement range
	function automatic logic signed [33:0] btx_sat(input logic signed [33:0] v, input int n);
		logic signed [33:0] hi;
		logic signed [33:0] lo;
		hi = (34'sh1 <<< (n - 1)) - 34'sh1;
		lo = -hi - 34'sh1;
		if (v > hi)
			return hi;
		if (v < lo)
			return lo;
		return v;
	endfunction

endpackage

/* btx_stage_if.sv */
`timescale 1ns/10ps
// one matrix stage: sample feed in, serial results out
interface btx_stage_if
	import btx_pkg::*;
#(
	parameter int IW = 12,
	parameter int OW = 29,
	parameter int TW = 10
);
	logic                 inValid;
	logic [2:0]           inM;
	logic signed [IW-1:0] inData;
	btxFunc_t             inFunc;
	logic [TW-1:0]        inTag;
	logic                 outValid;
	logic [2:0]           outK;
	logic signed [OW-1:0] outData;
	logic [TW-1:0]        outTag;

	modport feed (output inValid, inM, inData, inFunc, inTag,
		input outValid, outK, outData, outTag);
	modport stage (input inValid, inM, inData, inFunc, inTag,
		output outValid, outK, outData, outTag);
endinterface

/* btx_stream_partner.sv */
`timescale 1ns/10ps
// codec-side model: feeds sample blocks and collects the results
module btx_stream_partner
(
	input  wire logic               clk,         // system clock
	input  wire logic signed [11:0] resultOut,   // result sample
	input  wire logic               resultValid, // result stream active
	input  wire logic               resultFirst, // first result of a block
	output logic                    blockStart,  // block start strobe
	output logic [2:0]              funcSel,     // function select
	output logic signed [11:0]      pixelIn,     // input sample
	output logic signed [8:0]       auxOp        // auxiliary operand
);
	logic signed [11:0] pix[0:127];
	logic signed [8:0]  aux[0:127];
	logic [2:0]         sel[0:1];
	logic signed [11:0] got[0:127];
	int                 firstAt[0:1];
	int                 nBlk;
	int                 auxLag;
	int                 k = -1;
	int                 nGot;
	int                 nFirst;

	// quiet values before the first falling edge
	initial
	begin
		blockStart = 1'b0;
		funcSel = 3'h0;
		pixelIn = 12'sh000;
		auxOp = 9'sh000;
	end

	// one step per falling edge, k counts cycles from the block start
	always @(negedge clk)
	begin
		if (k >= 0)
		begin
			if (resultFirst === 1'b1 && nFirst < 2)
			begin
				firstAt[nFirst] = k;
				nFirst++;
			end
			if (resultValid === 1'b1 && nGot < 128)
			begin
				got[nGot] = resultOut;
				nGot++;
			end
		end
		// strobe and select with sample 0, blocks back to back
		if (k >= 0 && k < 64 * nBlk)
		begin
			// a stray strobe and a wrong select mid-block must be ignored
			blockStart = (k % 64 == 0) || (k % 64 == 32);
			funcSel = (k % 64 == 0) ? sel[k / 64] : ~sel[k / 64];
			pixelIn = pix[k];
		end
		else
		begin
			blockStart = 1'b0;
			funcSel = ~funcSel;
			pixelIn = ~pixelIn;
		end
		// operand aligned to the input or to the output
		if (k - auxLag >= 0 && k - auxLag < 64 * nBlk)
			auxOp = aux[k - auxLag];
		else
			auxOp = ~auxOp;
		if (k >= 0)
			k = (k < 64 * nBlk + 140) ? k + 1 : -1;
	end
endmodule
